// ### hw/rhd_cfg_refresh.sv
`timescale 1ns/1ps
module rhd_cfg_refresh #(
  parameter int INTV_W = 14
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // configuration access, one dword at a time
  input  wire logic [7:0]           cfg_addr,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [3:0]           cfg_be,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  output logic                      cfg_ack,
  // reset-time host address straps
  input  wire logic [12:5]          strap_addr,
  // memory controller side
  input  wire logic                 mem_idle,
  output logic                      refresh_busy,
  output logic                      refresh_envelope_out,
  output logic                      column_strobe_n,
  output logic                      row_strobe_n,
  output logic                      edo_detect_mode,
  output logic                      cke_mux_mode,
  // host interface options
  output logic                      cas_crossbar,
  output logic                      fast_decode,
  output logic [3:0]                ioq_depth,
  output logic [2:0]                rd_buf_lines,
  output logic                      wbuf_extra_clk,
  // outbound request decode
  input  wire logic                 req_valid,
  input  wire logic [31:0]          req_addr,
  input  wire logic                 req_io,
  input  wire logic                 req_write,
  input  wire logic                 req_smm,
  input  wire logic                 req_code,
  output logic                      out_valid,
  output rhd_pkg::rhd_dest_t        out_dest,
  output logic      [31:0]          out_addr
);
  import rhd_pkg::*;

  typedef enum logic [2:0] {
    RF_IDLE = 3'b000,
    RF_WAIT = 3'b001,
    RF_LEAD = 3'b010,
    RF_LOW  = 3'b011,
    RF_PRE  = 3'b100
  } rhd_rf_state_t;

  logic [31:0]        mem_cmd_r;
  logic [15:0]        host_if_r;
  logic [7:0]         out_dec_r;
  logic [7:0]         win_smm_r;
  logic [7:0]         strap_r;
  logic               strap_take_r;
  logic [INTV_W-1:0]  intv_cnt_r;
  logic [2:0]         pend_r;
  logic [5:0]         idle_cnt_r;
  logic [2:0]         ph_cnt_r;
  rhd_rf_state_t      rf_state_r;
  rhd_rf_state_t      rf_state_nxt;

  // byte-lane merge of a write under its writable mask
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] wmask, input logic [3:0] be);
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~lane) | (new_v & lane);
  endfunction

  // inclusive range test on an address
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // address decode: 7ch dword and 80h dword (host, outbound, window bytes)
  wire        sel_mc   = (cfg_addr[7:2] == OFS_MEM_CMD[7:2]);
  wire        sel_hi   = (cfg_addr[7:2] == OFS_HOST_IF[7:2]);
  wire [31:0] hi_word  = {win_smm_r, out_dec_r, host_if_r};
  wire [31:0] hi_wmask = {WIN_SMM_WMASK, OUT_DEC_WMASK, HOST_IF_WMASK};
  wire [31:0] mc_new   = merge(mem_cmd_r, cfg_wdata, MEM_CMD_WMASK, cfg_be);
  wire [31:0] hi_new   = merge(hi_word, cfg_wdata, hi_wmask, cfg_be);
  wire [31:0] rd_word  = sel_mc ? mem_cmd_r : (sel_hi ? hi_word : 32'h0000_0000);

  // write strobes per dword, gated by the clock enable
  wire        wr_mc    = ce && cfg_wr && sel_mc;
  wire        wr_hi    = ce && cfg_wr && sel_hi;

  // latched strap view folded into host interface read-only bits
  wire [15:0] host_view = {host_if_r[15:13],       // reserved and upper options
                           strap_r[2],             // global queue depth, address line 7
                           host_if_r[11:10],       // local queue depth
                           strap_r[7:6],           // cluster id, address lines 12:11
                           strap_r[5:3],           // init, bus error, address error observation
                           strap_r[1:0],           // reset vector and redundancy check mode
                           host_if_r[2:0]};

  // refresh control fields
  wire              rfh_en    = mem_cmd_r[MC_RFH_EN];
  wire              q_mode    = mem_cmd_r[MC_RQ_DEPTH];
  wire [INTV_W-1:0] intv_val  = mem_cmd_r[MC_INTV_LO +: INTV_W];
  wire [2:0]        lead_clk  = mem_cmd_r[MC_CAS_RAS] ? 3'h2 : 3'h1;
  wire [2:0]        low_clk   = RAS_LOW_BASE + {1'b0, mem_cmd_r[MC_RAS_LOW_LO +: 2]};
  wire [2:0]        pre_clk   = RAS_PRE_BASE + {1'b0, mem_cmd_r[MC_RAS_PRE_LO +: 2]};
  wire [5:0]        idle_need = 6'((mem_cmd_r[MC_RQ_IDLE_LO +: 3] + 4'h1) * IDLE_STEP);
  wire              expire    = rfh_en && (intv_cnt_r <= INTV_W'(1));
  wire [2:0]        pend_cap  = q_mode ? QUEUE_MAX : 3'h1;
  wire              start_ok  = (pend_r != 3'h0) && (!q_mode || (idle_cnt_r >= idle_need));
  wire              ph_done   = (ph_cnt_r <= 3'h1);
  wire              rf_take   = (rf_state_r == RF_WAIT) && start_ok && rfh_en;

  // phase flags of the next state, shared by the pin registers
  wire              lead_nxt  = (rf_state_nxt == RF_LEAD);
  wire              low_nxt   = (rf_state_nxt == RF_LOW);
  wire              busy_nxt  = lead_nxt || low_nxt || (rf_state_nxt == RF_PRE);

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mem_cmd_r <= MEM_CMD_RST;
      host_if_r <= HOST_IF_RST;
      out_dec_r <= OUT_DEC_RST;
      win_smm_r <= WIN_SMM_RST;
    end else if (wr_mc) begin
      mem_cmd_r <= mc_new;
    end else if (wr_hi) begin
      host_if_r <= hi_new[15:0];
      out_dec_r <= hi_new[23:16];
      win_smm_r <= hi_new[31:24];
    end
  end

  // straps follow the pins while reset is held and on the first enabled clock after it, then freeze
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      strap_take_r <= 1'b1;
    end else if (ce) begin
      strap_take_r <= 1'b0;
    end
  end

  // strap capture register, frozen with the clock enable
  always_ff @(posedge ref_clk) begin
    if (!rstn || (ce && strap_take_r)) begin
      strap_r <= strap_addr;
    end
  end

  // read data and acknowledge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack   <= 1'b0;
    end else if (ce) begin
      cfg_ack   <= cfg_wr || cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= sel_hi ? {rd_word[31:16], host_view} : rd_word;
      end
    end
  end

  // interval counter reloads on every expiry; a write to the
  // command dword restarts it from the new count at once
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      intv_cnt_r <= INTV_W'(MEM_CMD_RST[MC_INTV_LO +: INTV_W]);
    end else if (ce) begin
      if (wr_mc) begin
        intv_cnt_r <= mc_new[MC_INTV_LO +: INTV_W];
      end else if (!rfh_en || expire) begin
        intv_cnt_r <= intv_val;
      end else begin
        intv_cnt_r <= intv_cnt_r - INTV_W'(1);
      end
    end
  end

  // pending refresh requests, queue of four or direct
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pend_r <= 3'h0;
    end else if (ce) begin
      if (!rfh_en) begin
        pend_r <= 3'h0;
      end else if (expire && !rf_take && (pend_r < pend_cap)) begin
        pend_r <= pend_r + 3'h1;
      end else if (rf_take && !(expire && (pend_r <= pend_cap))) begin
        pend_r <= pend_r - 3'h1;
      end
    end
  end

  // idle clocks seen on the memory bus
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idle_cnt_r <= 6'h00;
    end else if (ce) begin
      if (!mem_idle || rf_take) begin
        idle_cnt_r <= 6'h00;
      end else if (idle_cnt_r != 6'h3f) begin
        idle_cnt_r <= idle_cnt_r + 6'h01;
      end
    end
  end

  // refresh cycle sequencer
  always_comb begin
    case (rf_state_r)
      RF_IDLE: rf_state_nxt = rfh_en ? RF_WAIT : RF_IDLE;
      RF_WAIT: rf_state_nxt = !rfh_en ? RF_IDLE : (rf_take ? RF_LEAD : RF_WAIT);
      RF_LEAD: rf_state_nxt = ph_done ? RF_LOW : RF_LEAD;
      RF_LOW:  rf_state_nxt = ph_done ? RF_PRE : RF_LOW;
      RF_PRE:  rf_state_nxt = ph_done ? RF_IDLE : RF_PRE;
      default: rf_state_nxt = RF_IDLE;
    endcase
  end

  // sequencer state and phase length counter
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rf_state_r <= RF_IDLE;
      ph_cnt_r   <= 3'h0;
    end else if (ce) begin
      rf_state_r <= rf_state_nxt;
      case (rf_state_r)
        RF_WAIT: ph_cnt_r <= lead_clk;
        RF_LEAD: ph_cnt_r <= ph_done ? low_clk : ph_cnt_r - 3'h1;
        RF_LOW:  ph_cnt_r <= ph_done ? pre_clk : ph_cnt_r - 3'h1;
        default: ph_cnt_r <= ph_cnt_r - 3'h1;
      endcase
    end
  end

  // strobe and envelope pins, column leads row, both rise together
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      column_strobe_n      <= 1'b1;
      row_strobe_n         <= 1'b1;
      refresh_envelope_out <= 1'b0;
      refresh_busy         <= 1'b0;
    end else if (ce) begin
      column_strobe_n      <= !(lead_nxt || low_nxt);
      row_strobe_n         <= !low_nxt;
      refresh_envelope_out <= mem_cmd_r[MC_ENV_EN] && busy_nxt;
      refresh_busy         <= busy_nxt;
    end
  end

  // option outputs to the rest of the bridge
  wire [3:0] lioq      = 4'h1 << host_if_r[HC_LIOQ_LO +: 2];
  wire [3:0] gioq      = strap_r[2] ? 4'h1 : 4'h8;
  wire [3:0] ioq_sel   = (lioq < gioq) ? lioq : gioq;
  wire [2:0] rdbuf_sel = (host_if_r[HC_RDBUF_LO +: 2] == 2'b10) ? 3'h4 :
                         (host_if_r[HC_RDBUF_LO +: 2] == 2'b01) ? 3'h2 : 3'h1;

  // option registers, one clock behind the configuration bits
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      edo_detect_mode <= 1'b0;
      cke_mux_mode    <= 1'b0;
      cas_crossbar    <= 1'b0;
      fast_decode     <= 1'b0;
      ioq_depth       <= 4'h1;
      rd_buf_lines    <= 3'h1;
      wbuf_extra_clk  <= 1'b1;
    end else if (ce) begin
      edo_detect_mode <= mem_cmd_r[MC_EDO_DET];
      cke_mux_mode    <= out_dec_r[OD_NOT4_DIMM];
      cas_crossbar    <= host_if_r[HC_CAS_XBAR];
      fast_decode     <= host_if_r[HC_FAST_DEC];
      ioq_depth       <= ioq_sel;
      rd_buf_lines    <= rdbuf_sel;
      wbuf_extra_clk  <= host_if_r[HC_WSLOW];
    end
  end

  // outbound decode of one request
  wire [15:0] io_lo     = req_addr[15:0];
  wire [3:0]  io_port   = io_lo[3:0];
  wire        mono_io   = (io_lo[15:4] == MONO_IO_BASE[15:4]) && MONO_IO_PORTMAP[io_port];
  wire        mono_hit  = out_dec_r[OD_MONO] &&
                          (req_io ? mono_io : in_range(req_addr, MONO_MEM_LO, MONO_MEM_HI));
  wire        alias_hit = out_dec_r[OD_ISA_ALIAS] && (req_addr[9:8] != 2'b00);
  wire [31:0] io_addr   = {out_dec_r[OD_HIO_MASK] ? 16'h0000 : req_addr[31:16],
                           alias_hit ? 6'h00 : req_addr[15:10], req_addr[9:0]};
  wire        remap_hit = win_smm_r[WS_REMAP] && req_smm && in_range(req_addr, SMM_DEF_LO, SMM_DEF_HI);
  wire [31:0] mem_addr  = remap_hit ? req_addr + SMM_REMAP_OFS : req_addr;
  wire        win_hit   = in_range(mem_addr, LEG_WIN_LO, LEG_WIN_HI);
  wire        win_en    = req_write ? win_smm_r[WS_WR_EN] : win_smm_r[WS_RD_EN];
  wire [1:0]  smm_mode  = win_smm_r[WS_MODE_LO +: 2];
  wire        smm_dram  = (smm_mode == SMM_OPEN) || (req_smm &&
                          ((smm_mode == SMM_PROTECTED) || req_code));

  // destination choice, memory above the window goes to dram
  rhd_dest_t  dest_sel;
  assign dest_sel = req_io ? (mono_hit ? DEST_PCI : DEST_AGP) :
                    mono_hit ? DEST_PCI :
                    !win_hit ? DEST_DRAM :
                    (win_en && smm_dram) ? DEST_DRAM : DEST_PCI;

  // registered decode result, held until the next request
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_dest  <= DEST_DRAM;
      out_addr  <= 32'h0000_0000;
    end else if (ce) begin
      out_valid <= req_valid;
      if (req_valid) begin
        out_dest <= dest_sel;
        out_addr <= req_io ? io_addr : mem_addr;
      end
    end
  end
endmodule

// ### hw/rhd_pkg.sv
package rhd_pkg;
  // register offsets on the configuration space
  localparam logic [7:0]  OFS_MEM_CMD      = 8'h7c;
  localparam logic [7:0]  OFS_HOST_IF      = 8'h80;
  localparam logic [7:0]  OFS_OUT_DEC      = 8'h82;
  localparam logic [7:0]  OFS_WIN_SMM      = 8'h83;
  // memory_command_ctrl field positions
  localparam int          MC_RQ_DEPTH      = 27;
  localparam int          MC_RQ_IDLE_LO    = 24;
  localparam int          MC_ENV_EN        = 21;
  localparam int          MC_EDO_DET       = 20;
  localparam int          MC_RFH_EN        = 19;
  localparam int          MC_CAS_RAS       = 18;
  localparam int          MC_RAS_LOW_LO    = 16;
  localparam int          MC_RAS_PRE_LO    = 14;
  localparam int          MC_INTV_LO       = 0;
  // host_interface_cfg field positions
  localparam int          HC_CAS_XBAR      = 15;
  localparam int          HC_FAST_DEC      = 14;
  localparam int          HC_GIOQ          = 12;
  localparam int          HC_LIOQ_LO       = 10;
  localparam int          HC_RDBUF_LO      = 1;
  localparam int          HC_WSLOW         = 0;
  // outbound_decode_cfg field positions
  localparam int          OD_NOT4_DIMM     = 4;
  localparam int          OD_MONO          = 2;
  localparam int          OD_HIO_MASK      = 1;
  localparam int          OD_ISA_ALIAS     = 0;
  // legacy_window_smm_ctrl field positions
  localparam int          WS_RD_EN         = 7;
  localparam int          WS_WR_EN         = 6;
  localparam int          WS_MODE_LO       = 4;
  localparam int          WS_REMAP         = 3;
  localparam int          WS_USWC          = 2;
  // reset values
  localparam logic [31:0] MEM_CMD_RST      = 32'h00c7_c411;
  localparam logic [15:0] HOST_IF_RST      = 16'h0c01;
  localparam logic [7:0]  OUT_DEC_RST      = 8'h00;
  localparam logic [7:0]  WIN_SMM_RST      = 8'h08;
  // writable masks
  localparam logic [31:0] MEM_CMD_WMASK    = 32'hffff_ffff;
  localparam logic [15:0] HOST_IF_WMASK    = 16'hcc07;
  localparam logic [7:0]  OUT_DEC_WMASK    = 8'hf7;
  localparam logic [7:0]  WIN_SMM_WMASK    = 8'hfc;
  // refresh timing bases in host clocks, and refresh queue depth
  localparam logic [2:0]  RAS_LOW_BASE     = 3'h3;
  localparam logic [2:0]  RAS_PRE_BASE     = 3'h2;
  localparam logic [5:0]  IDLE_STEP        = 6'h05;
  localparam logic [2:0]  QUEUE_MAX        = 3'h4;
  // address windows
  localparam logic [31:0] LEG_WIN_LO       = 32'h000a_0000;
  localparam logic [31:0] LEG_WIN_HI       = 32'h000b_ffff;
  localparam logic [31:0] MONO_MEM_LO      = 32'h000b_0000;
  localparam logic [31:0] MONO_MEM_HI      = 32'h000b_7fff;
  localparam logic [31:0] SMM_DEF_LO       = 32'h0003_8000;
  localparam logic [31:0] SMM_DEF_HI       = 32'h0003_ffff;
  localparam logic [31:0] SMM_REMAP_OFS    = 32'h0007_0000;
  localparam logic [15:0] MONO_IO_BASE     = 16'h03b0;
  localparam logic [15:0] MONO_IO_PORTMAP  = 16'h8730;

  typedef enum logic [1:0] {
    SMM_CLOSED    = 2'b00,
    SMM_OPEN      = 2'b01,
    SMM_LOCKED    = 2'b10,
    SMM_PROTECTED = 2'b11
  } rhd_smm_mode_t;

  typedef enum logic [1:0] {
    DEST_DRAM = 2'b00,
    DEST_PCI  = 2'b01,
    DEST_AGP  = 2'b10
  } rhd_dest_t;
endpackage

// ### verif/rhd_cfg_refresh_monitor.sv
`timescale 1ns/1ps
// port-level timing checks on the config handshake, decode pipe and refresh strobes
module rhd_cfg_refresh_monitor #(
  parameter int INTV_W = 14
) (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic       cfg_ack,
  input wire logic       req_valid,
  input wire logic       out_valid,
  input wire logic       refresh_busy,
  input wire logic       refresh_envelope_out,
  input wire logic       column_strobe_n,
  input wire logic       row_strobe_n,
  input wire logic [3:0] ioq_depth,
  input wire logic [2:0] rd_buf_lines
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // handshake and pipe latency
  a_ack_after_req: assert property (ce && (cfg_wr || cfg_rd) |=> cfg_ack)
    else $error("config access not acknowledged one cycle later");
  a_ack_has_cause: assert property (cfg_ack |-> $past(cfg_wr) || $past(cfg_rd))
    else $error("config acknowledge without an access");
  a_dec_one_cycle: assert property (ce && req_valid |=> out_valid)
    else $error("decoded request not presented one cycle later");
  a_dec_no_spur: assert property (out_valid |-> $past(req_valid))
    else $error("decode output without a request");
  // refresh strobe shape
  a_strobe_idle: assert property (!refresh_busy |-> column_strobe_n && row_strobe_n)
    else $error("refresh strobe low outside a refresh cycle");
  a_col_to_row: assert property ($fell(column_strobe_n) |-> row_strobe_n ##[1:2] $fell(row_strobe_n))
    else $error("column to row strobe lead out of range");
  a_row_low_len: assert property ($fell(row_strobe_n) |-> (!row_strobe_n)[*3] ##[1:4] row_strobe_n)
    else $error("row strobe low time out of range");
  a_precharge_min: assert property ($rose(row_strobe_n) |-> (row_strobe_n && column_strobe_n && refresh_busy)[*2])
    else $error("refresh precharge shorter than two clocks");
  a_env_in_busy: assert property (refresh_envelope_out |-> refresh_busy)
    else $error("refresh envelope high outside a refresh cycle");
  // option outputs stay legal
  a_rdbuf_code: assert property (rd_buf_lines inside {3'h1, 3'h2, 3'h4})
    else $error("read buffer line count illegal");
  a_ioq_code: assert property ($onehot(ioq_depth))
    else $error("queue depth not a power of two");
endmodule

bind rhd_cfg_refresh rhd_cfg_refresh_monitor #(.INTV_W(INTV_W)) i_rhd_cfg_refresh_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_ack(cfg_ack),
  .req_valid(req_valid), .out_valid(out_valid), .refresh_busy(refresh_busy),
  .refresh_envelope_out(refresh_envelope_out), .column_strobe_n(column_strobe_n),
  .row_strobe_n(row_strobe_n), .ioq_depth(ioq_depth), .rd_buf_lines(rd_buf_lines));

// ### verif/rhd_cfg_refresh_tb.sv
`timescale 1ns/1ps
// randomised bench: strap capture, config space, decode routing, refresh timing
module rhd_cfg_refresh_tb;
  import rhd_pkg::*;
  localparam logic [31:0] BASES [4] = '{32'h38000, 32'ha0000, 32'hb0000, 32'h100000};
  logic        ref_clk, rstn, ce, cfg_wr, cfg_rd, cfg_ack, mem_idle, req_valid, req_io, req_write;
  logic        req_smm, req_code, out_valid, refresh_busy, refresh_envelope_out, column_strobe_n;
  logic        row_strobe_n, edo_detect_mode, cke_mux_mode, cas_crossbar, fast_decode, wbuf_extra_clk;
  logic [3:0]  cfg_be, ioq_depth;
  logic [7:0]  cfg_addr;
  logic [12:5] strap_addr, s;
  logic [2:0]  rd_buf_lines;
  logic [31:0] cfg_wdata, cfg_rdata, req_addr, out_addr, rd, hcfg, mcmd;
  rhd_dest_t   out_dest;
  int          n_mismatch, checks, lead, low, pre, per, n, f;

  rhd_cfg_refresh #(.INTV_W(14)) i_rhd_cfg_refresh (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .strap_addr(strap_addr),
    .mem_idle(mem_idle), .refresh_busy(refresh_busy), .refresh_envelope_out(refresh_envelope_out),
    .column_strobe_n(column_strobe_n), .row_strobe_n(row_strobe_n), .edo_detect_mode(edo_detect_mode),
    .cke_mux_mode(cke_mux_mode), .cas_crossbar(cas_crossbar), .fast_decode(fast_decode),
    .ioq_depth(ioq_depth), .rd_buf_lines(rd_buf_lines), .wbuf_extra_clk(wbuf_extra_clk),
    .req_valid(req_valid), .req_addr(req_addr), .req_io(req_io), .req_write(req_write), .req_smm(req_smm),
    .req_code(req_code), .out_valid(out_valid), .out_dest(out_dest), .out_addr(out_addr));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask

  // one config access; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cyc();
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    n = 0;
    while (cfg_ack !== 1'b1 && n < 4) begin
      cyc();
      n++;
    end
    if (n == 4) begin
      n_mismatch++;
      close_out();
    end
    rd = cfg_rdata;
    cyc();
  endtask

  // byte-enabled write honouring the read-only bits
  function automatic logic [31:0] merge(input logic [31:0] o, w, input logic [3:0] be, input logic [31:0] m);
    for (int i = 0; i < 4; i++)
      if (be[i]) o[8*i+:8] = (w[8*i+:8] & m[8*i+:8]) | (o[8*i+:8] & ~m[8*i+:8]);
    return o;
  endfunction

  // host byte pair after reset with the latched straps
  function automatic logic [15:0] hrst(input logic [12:5] t);
    return {3'h0, t[7], HOST_IF_RST[11:10], t[12:11], t[10], t[9], t[8], t[6], t[5], HOST_IF_RST[2:0]};
  endfunction

  // expected destination and address of a request
  function automatic logic [33:0] route(input logic [31:0] a, input logic io, w, smm, code);
    logic [1:0] d;
    if (io) begin
      d = (hcfg[18] && a[15:0] inside {16'h3b4, 16'h3b5, 16'h3b8, 16'h3b9, 16'h3ba, 16'h3bf}) ? DEST_PCI : DEST_AGP;
      if (hcfg[17]) a[31:16] = 16'h0;
      if (hcfg[16] && a[9:8] != 2'h0) a[15:10] = 6'h0;
    end else begin
      if (smm && hcfg[27] && a >= 32'h38000 && a <= 32'h3ffff) a = a + 32'h70000;
      d = DEST_DRAM;
      if (a >= 32'ha0000 && a <= 32'hbffff) begin
        if (!(w ? hcfg[30] : hcfg[31])) d = DEST_PCI;
        else if (smm) d = (hcfg[28] || code) ? DEST_DRAM : DEST_PCI;
        else d = (hcfg[29:28] == 2'b01) ? DEST_DRAM : DEST_PCI;
      end
      if (hcfg[18] && a >= 32'hb0000 && a <= 32'hb7fff) d = DEST_PCI;
    end
    return {d, a};
  endfunction

  task automatic opts();
    logic [3:0] l;
    l = 4'h1 << hcfg[11:10];
    check(ioq_depth, s[7] ? 4'h1 : l);
    check(rd_buf_lines, hcfg[2:1] == 2'h2 ? 3'h4 : hcfg[2:1] == 2'h1 ? 3'h2 : 3'h1);
    check({cas_crossbar, fast_decode, wbuf_extra_clk, cke_mux_mode, edo_detect_mode},
          {hcfg[15], hcfg[14], hcfg[0], hcfg[20], mcmd[20]});
  endtask

  // back-to-back random requests
  task automatic decode(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      req_io = 1'($urandom);
      req_write = 1'($urandom);
      req_smm = 1'($urandom);
      req_code = 1'($urandom);
      req_addr = $urandom;
      if (req_io && req_addr[0]) req_addr[15:4] = 12'h03b;
      if (req_io && !hcfg[17]) req_addr[31:16] = 16'h0;
      if (!req_io) req_addr = BASES[req_addr[17:16]] + {17'h0, req_addr[14:0]};
      req_valid = 1'b1;
      cyc();
      check(out_valid, 1'b1);
      check({out_dest, out_addr}, route(req_addr, req_io, req_write, req_smm, req_code));
    end
    req_valid = 1'b0;
  endtask

  // count refresh starts over a stretch of cycles
  task automatic quiet(input int cnt);
    logic p;
    f = 0;
    p = column_strobe_n;
    repeat (cnt) begin
      cyc();
      if (p === 1'b1 && column_strobe_n === 1'b0) f++;
      p = column_strobe_n;
    end
  endtask

  // time one refresh cycle and the spacing to the next
  task automatic refresh(input logic [31:0] v);
    mcmd = v;
    bus(1'b1, OFS_MEM_CMD, 4'hf, v);
    opts();
    {lead, low, pre, n} = '0;
    while (column_strobe_n !== 1'b0 && n < 200) begin cyc(); n++; end
    f = n;
    while (row_strobe_n !== 1'b0 && n < 200) begin cyc(); n++; lead++; end
    while (row_strobe_n !== 1'b1 && n < 200) begin cyc(); n++; low++; end
    while (refresh_busy !== 1'b0 && n < 200) begin check(refresh_envelope_out, v[21]); cyc(); n++; pre++; end
    check(refresh_envelope_out, 1'b0);
    while (column_strobe_n !== 1'b0 && n < 200) begin cyc(); n++; end
    if (n >= 200) begin
      n_mismatch++;
      close_out();
    end
    check(lead, v[18] ? 2 : 1);
    check(low, 3 + v[17:16]);
    check(pre, 2 + v[15:14]);
    check(n - f, v[13:0]);
    mcmd[19] = 1'b0;
    bus(1'b1, OFS_MEM_CMD, 4'hf, mcmd);
    repeat (16) cyc();
    quiet(64);
    check(f, 0);
  endtask

  // cut a hang short
  initial begin
    #2500000;
    n_mismatch++;
    close_out();
  end

  initial begin
    logic [31:0] w;
    logic [3:0]  be;
    void'($urandom(32'h78635539));
    {ce, mem_idle, rstn} = 3'b110;
    {cfg_wr, cfg_rd, req_valid, req_io, req_write, req_smm, req_code} = '0;
    {cfg_addr, cfg_be, cfg_wdata, req_addr} = '0;
    s = 8'($urandom);
    strap_addr = s;
    repeat (4) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    cyc();
    cyc();
    strap_addr = ~s;
    mcmd = MEM_CMD_RST;
    hcfg = {WIN_SMM_RST, OUT_DEC_RST, hrst(s)};
    opts();
    bus(1'b0, OFS_MEM_CMD, 4'hf, 32'h0);
    check(rd, mcmd);
    bus(1'b0, OFS_HOST_IF, 4'hf, 32'h0);
    check(rd, hcfg);
    bus(1'b1, 8'h40, 4'hf, 32'hffff_ffff);
    bus(1'b0, 8'h40, 4'hf, 32'h0);
    check(rd, 32'h0);
    decode(16);
    for (int k = 0; k < 24; k++) begin
      w = $urandom;
      w[29:28] = k[1:0];
      if (s[7]) w[11:10] = 2'h0;
      be = (k < 4) ? 4'hf : 4'($urandom);
      bus(1'b1, OFS_HOST_IF, be, w);
      hcfg = merge(hcfg, w, be, {WIN_SMM_WMASK, OUT_DEC_WMASK, HOST_IF_WMASK});
      bus(1'b0, OFS_HOST_IF, 4'hf, 32'h0);
      check(rd, hcfg);
      opts();
      decode(12);
    end
    for (int k = 0; k < 4; k++)
      refresh({10'h0, k[0], k[1], 1'b1, k[0] ^ k[1], k[1:0], ~k[1:0], 14'(30 + $urandom % 16)});
    // queued refresh waits for idle memory
    mem_idle = 1'b0;
    bus(1'b1, OFS_MEM_CMD, 4'hf, 32'h0808_001e);
    quiet(100);
    check(f, 0);
    mem_idle = 1'b1;
    n = 0;
    while (column_strobe_n !== 1'b0 && n < 12) begin cyc(); n++; end
    check(n >= 5 && n < 12, 1'b1);
    close_out();
  end
endmodule
